// File: dapid_pkg.sv
// Package of offsets, field layouts and reset values for the debug identity block
// Function
// - Second port ident reports size field 0x0C
// - Only lowest 4KB of access port reachable
// - Access port serves the single debug port
// - Base pointer zero field reads 0x000
// - Base pointer zero valid bit reads one
// - Target ident bits 31:1 follow target input bus, bit 0 reads one
// - Instance field follows instance ident input
// - Peripheral variant base equals ROM parameter
// - Peripheral variant entry bit reads one
// - ROM maker fields from maker code input
// - ROM revision field from revision input
// - ROM part fields from part input
// - System variant base follows location input
// - System variant entry bit follows valid input
// - Register offsets fixed from component base
// - Registers take reset values on reset
package dapid_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [11:0] DAPID_OFS_PORT_ID2   = 12'h000;
    localparam logic [11:0] DAPID_OFS_BASE_POINTER_ZERO_REG   = 12'h004;
    localparam logic [11:0] DAPID_OFS_TARGET_ID  = 12'h008;
    localparam logic [11:0] DAPID_OFS_LINK_ID    = 12'h00C;
    localparam logic [11:0] DAPID_OFS_AP_BASE    = 12'h010;
    localparam logic [11:0] DAPID_OFS_PERIPH_IDENT_REG_ZERO      = 12'h014;
    localparam logic [11:0] DAPID_OFS_PERIPH_IDENT_REG_ONE      = 12'h018;
    localparam logic [11:0] DAPID_OFS_PERIPH_IDENT_REG_TWO      = 12'h01C;
    localparam logic [11:0] DAPID_OFS_PERIPH_IDENT_REG_FOUR      = 12'h020;
    localparam logic [11:0] DAPID_OFS_SCRATCH    = 12'h024;
    localparam logic [11:0] DAPID_OFS_STATUS     = 12'h028;
    // ==========================================================
    // Fixed field values
    localparam logic [7:0]  DAPID_ADDR_SPACE_SIZE_FIELD_VAL      = 8'h0C;
    localparam logic [11:0] DAPID_PTR_VAL        = 12'h000;
    localparam logic        DAPID_PTR_VALID      = 1'b1;
    localparam logic        DAPID_ENTRY_APB      = 1'b1;
    localparam int          DAPID_ADDR_BITS      = 12;
    localparam logic [31:0] DAPID_ZERO           = 32'h0000_0000;
    localparam logic [31:0] DAPID_SCRATCH_RST    = 32'h0000_0000;
    // Status: bit0 last access hit unmapped, bit1 variant
    localparam int          DAPID_ST_UNMAP       = 0;
    localparam int          DAPID_ST_VARIANT     = 1;
endpackage

// File: dapid_top.sv
// Identity and configuration register block of the debug access port
//
// Local design decisions: the APB register port and the register offsets.
`timescale 1ns/100ps
module dapid_top
    import dapid_pkg::*;
#(
    parameter bit          SYS_VARIANT   = 1'b0,
    parameter logic [19:0] ROM_BASE_ADDR = 20'h00000
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Integration identity inputs
    input  wire logic [31:0] target_ident_input,
    input  wire logic [3:0]  instance_ident_input,
    input  wire logic [10:0] rom_maker_code_input,
    input  wire logic [3:0]  rom_revision_input,
    input  wire logic [11:0] rom_part_input,
    input  wire logic [19:0] port_location_input,
    input  wire logic        port_location_ok_input
);
    // ==========================================================
    // Register images
    logic [31:0] scratch_q;
    logic        unmap_q;
    logic [31:0] prdata_q;
    logic        pready_q;
    logic        pslverr_q;

    wire         acc_setup  = psel && !penable;
    wire [31:0]  port_id2   = {24'h0, DAPID_ADDR_SPACE_SIZE_FIELD_VAL};
    wire [31:0]  base_pointer_zero_reg   = {DAPID_PTR_VAL, 19'h0, DAPID_PTR_VALID};
    wire [31:0]  target_id  = {target_ident_input[31:1], 1'b1};
    wire [31:0]  link_id    = {instance_ident_input, 27'h0, 1'b1};
    wire [19:0]  base_addr  = SYS_VARIANT ? port_location_input : ROM_BASE_ADDR;
    wire         entry_ok   = SYS_VARIANT ? port_location_ok_input : DAPID_ENTRY_APB;
    wire [31:0]  ap_base    = {base_addr, 10'h0, 1'b1, entry_ok};
    wire [31:0]  periph_ident_reg_zero      = {24'h0, rom_part_input[7:0]};
    wire [31:0]  periph_ident_reg_one      = {24'h0, rom_maker_code_input[3:0], rom_part_input[11:8]};
    wire [31:0]  periph_ident_reg_two      = {24'h0, rom_revision_input, 1'b1, rom_maker_code_input[6:4]};
    wire [31:0]  periph_ident_reg_four      = {28'h0, rom_maker_code_input[10:7]};
    wire [31:0]  status     = {30'h0, SYS_VARIANT, unmap_q};

    // Single slave port only: one requester, no arbitration needed
    // Only the 12-bit window is decoded, so 4KB is all that is visible
    logic [31:0] rd_mux;
    logic        hit;
    always_comb begin
        rd_mux = DAPID_ZERO;
        hit    = 1'b1;
        if (paddr == DAPID_OFS_PORT_ID2) begin
            rd_mux = port_id2;
        end else if (paddr == DAPID_OFS_BASE_POINTER_ZERO_REG) begin
            rd_mux = base_pointer_zero_reg;
        end else if (paddr == DAPID_OFS_TARGET_ID) begin
            rd_mux = target_id;
        end else if (paddr == DAPID_OFS_LINK_ID) begin
            rd_mux = link_id;
        end else if (paddr == DAPID_OFS_AP_BASE) begin
            rd_mux = ap_base;
        end else if (paddr == DAPID_OFS_PERIPH_IDENT_REG_ZERO) begin
            rd_mux = periph_ident_reg_zero;
        end else if (paddr == DAPID_OFS_PERIPH_IDENT_REG_ONE) begin
            rd_mux = periph_ident_reg_one;
        end else if (paddr == DAPID_OFS_PERIPH_IDENT_REG_TWO) begin
            rd_mux = periph_ident_reg_two;
        end else if (paddr == DAPID_OFS_PERIPH_IDENT_REG_FOUR) begin
            rd_mux = periph_ident_reg_four;
        end else if (paddr == DAPID_OFS_SCRATCH) begin
            rd_mux = scratch_q;
        end else if (paddr == DAPID_OFS_STATUS) begin
            rd_mux = status;
        end else begin
            hit    = 1'b0;
        end
    end

    wire wr_scratch = acc_setup && pwrite && (paddr == DAPID_OFS_SCRATCH);

    // ==========================================================
    // Bus answer: one wait-free access phase after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q  <= DAPID_ZERO;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            scratch_q <= DAPID_SCRATCH_RST;
            unmap_q   <= 1'b0;
        end else begin
            pready_q  <= acc_setup;
            pslverr_q <= acc_setup && !hit;
            prdata_q  <= (acc_setup && !pwrite) ? rd_mux : DAPID_ZERO;
            if (wr_scratch) begin
                scratch_q <= pwdata;
            end
            if (acc_setup) begin
                unmap_q <= !hit;
            end
        end
    end
    // Identity writes are dropped silently; only the scratch word stores

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;

    // ==========================================================
    // Checks
    property p_addr_space_size_field;
        @(posedge pclk) disable iff (!presetn)
        (acc_setup && !pwrite && paddr == DAPID_OFS_PORT_ID2) |=> (prdata[7:0] == DAPID_ADDR_SPACE_SIZE_FIELD_VAL && pready);
    endproperty
    a_addr_space_size_field: assert property (p_addr_space_size_field) else $error("size field wrong");
    property p_bptr;
        @(posedge pclk) disable iff (!presetn)
        (acc_setup && !pwrite && paddr == DAPID_OFS_BASE_POINTER_ZERO_REG) |=> (prdata[31:20] == DAPID_PTR_VAL && prdata[0]);
    endproperty
    a_bptr: assert property (p_bptr) else $error("base pointer wrong");
    property p_tid;
        @(posedge pclk) disable iff (!presetn)
        (acc_setup && !pwrite && paddr == DAPID_OFS_TARGET_ID) |=> (prdata[31:1] == $past(target_ident_input[31:1]));
    endproperty
    a_tid: assert property (p_tid) else $error("target ident mismatch");
    property p_inst;
        @(posedge pclk) disable iff (!presetn)
        (acc_setup && !pwrite && paddr == DAPID_OFS_LINK_ID) |=> (prdata[31:28] == $past(instance_ident_input));
    endproperty
    a_inst: assert property (p_inst) else $error("instance mismatch");
    property p_base;
        @(posedge pclk) disable iff (!presetn)
        (acc_setup && !pwrite && paddr == DAPID_OFS_AP_BASE)
        |=> (prdata[31:12] == (SYS_VARIANT ? $past(port_location_input) : ROM_BASE_ADDR));
    endproperty
    a_base: assert property (p_base) else $error("ap base mismatch");
    property p_part;
        @(posedge pclk) disable iff (!presetn)
        (acc_setup && !pwrite && paddr == DAPID_OFS_PERIPH_IDENT_REG_ZERO) |=> (prdata[7:0] == $past(rom_part_input[7:0]));
    endproperty
    a_part: assert property (p_part) else $error("part field mismatch");
    property p_rev;
        @(posedge pclk) disable iff (!presetn)
        (acc_setup && !pwrite && paddr == DAPID_OFS_PERIPH_IDENT_REG_TWO) |=> (prdata[7:4] == $past(rom_revision_input));
    endproperty
    a_rev: assert property (p_rev) else $error("revision mismatch");
    property p_maker;
        @(posedge pclk) disable iff (!presetn)
        (acc_setup && !pwrite && paddr == DAPID_OFS_PERIPH_IDENT_REG_FOUR) |=> (prdata[3:0] == $past(rom_maker_code_input[10:7]));
    endproperty
    a_maker: assert property (p_maker) else $error("maker code mismatch");
    property p_entry_apb;
        @(posedge pclk) disable iff (!presetn)
        (!SYS_VARIANT && acc_setup && !pwrite && paddr == DAPID_OFS_AP_BASE) |=> (prdata[0] == DAPID_ENTRY_APB);
    endproperty
    a_entry_apb: assert property (p_entry_apb) else $error("entry bit low");

    // ==========================================================
    // Named steps of a transfer
    sequence s_rd(logic [11:0] ofs);
        acc_setup && !pwrite && paddr == ofs;
    endsequence

    sequence s_answer;
        pready && !pslverr;
    endsequence

    sequence s_refused;
        pready && pslverr;
    endsequence

    // ==========================================================
    // Field checks: fixed bits read their set values, other fields follow their sources
    property p_addr_space_size_field_high;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_PORT_ID2)
        |=> (prdata[31:8] == '0);
    endproperty
    a_addr_space_size_field_high: assert property (p_addr_space_size_field_high) else $error("size word upper bits set");

    property p_ptr_valid;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_BASE_POINTER_ZERO_REG)
        |=> (prdata[0] == DAPID_PTR_VALID);
    endproperty
    a_ptr_valid: assert property (p_ptr_valid) else $error("pointer valid bit low");

    property p_bptr_mid;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_BASE_POINTER_ZERO_REG)
        |=> (prdata[19:1] == '0);
    endproperty
    a_bptr_mid: assert property (p_bptr_mid) else $error("pointer middle bits set");

    property p_tid_bit0;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_TARGET_ID)
        |=> (prdata[0] == 1'b1);
    endproperty
    a_tid_bit0: assert property (p_tid_bit0) else $error("target ident bit0 low");

    property p_inst_low;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_LINK_ID)
        |=> (prdata[27:1] == '0 && prdata[0]);
    endproperty
    a_inst_low: assert property (p_inst_low) else $error("link ident low bits wrong");

    property p_base_mid;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_AP_BASE)
        |=> (prdata[11:1] == {10'h0, 1'b1});
    endproperty
    a_base_mid: assert property (p_base_mid) else $error("ap base middle bits wrong");

    property p_sys_entry;
        @(posedge pclk) disable iff (!presetn)
        (SYS_VARIANT && acc_setup && !pwrite && paddr == DAPID_OFS_AP_BASE)
        |=> (prdata[0] == $past(port_location_ok_input));
    endproperty
    a_sys_entry: assert property (p_sys_entry) else $error("entry bit not live");

    property p_sys_base;
        @(posedge pclk) disable iff (!presetn)
        (SYS_VARIANT && acc_setup && !pwrite && paddr == DAPID_OFS_AP_BASE)
        |=> (prdata[31:12] == $past(port_location_input));
    endproperty
    a_sys_base: assert property (p_sys_base) else $error("base not live");

    property p_periph_ident_reg_zero_high;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_PERIPH_IDENT_REG_ZERO)
        |=> (prdata[31:8] == '0);
    endproperty
    a_periph_ident_reg_zero_high: assert property (p_periph_ident_reg_zero_high) else $error("part word upper bits set");

    property p_des0;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_PERIPH_IDENT_REG_ONE)
        |=> (prdata[7:4] == $past(rom_maker_code_input[3:0]));
    endproperty
    a_des0: assert property (p_des0) else $error("maker low field wrong");

    property p_part1;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_PERIPH_IDENT_REG_ONE)
        |=> (prdata[3:0] == $past(rom_part_input[11:8]));
    endproperty
    a_part1: assert property (p_part1) else $error("part high field wrong");

    property p_des1;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_PERIPH_IDENT_REG_TWO)
        |=> (prdata[2:0] == $past(rom_maker_code_input[6:4]));
    endproperty
    a_des1: assert property (p_des1) else $error("maker middle field wrong");

    property p_periph_ident_reg_two_bit3;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_PERIPH_IDENT_REG_TWO)
        |=> (prdata[3] == 1'b1 && prdata[31:8] == '0);
    endproperty
    a_periph_ident_reg_two_bit3: assert property (p_periph_ident_reg_two_bit3) else $error("revision word fixed bits wrong");

    property p_periph_ident_reg_four_high;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_PERIPH_IDENT_REG_FOUR)
        |=> (prdata[31:4] == '0);
    endproperty
    a_periph_ident_reg_four_high: assert property (p_periph_ident_reg_four_high) else $error("maker word upper bits set");

    property p_status;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_STATUS)
        |=> (prdata[DAPID_ST_VARIANT] == SYS_VARIANT && prdata[DAPID_ST_UNMAP] == $past(unmap_q));
    endproperty
    a_status: assert property (p_status) else $error("status word wrong");

    property p_scratch_rd;
        @(posedge pclk) disable iff (!presetn)
        s_rd(DAPID_OFS_SCRATCH)
        |=> (prdata == $past(scratch_q));
    endproperty
    a_scratch_rd: assert property (p_scratch_rd) else $error("scratch read wrong");

    // ==========================================================
    // Bus handshake checks
    property p_answer;
        @(posedge pclk) disable iff (!presetn)
        (acc_setup && hit)
        |=> s_answer ##1 !pready;
    endproperty
    a_answer: assert property (p_answer) else $error("answer not a single pulse");

    property p_no_answer;
        @(posedge pclk) disable iff (!presetn)
        !acc_setup
        |=> (!pready && !pslverr);
    endproperty
    a_no_answer: assert property (p_no_answer) else $error("answer without request");

    property p_err_unmap;
        @(posedge pclk) disable iff (!presetn)
        (acc_setup && !hit)
        |=> s_refused ##1 !pslverr;
    endproperty
    a_err_unmap: assert property (p_err_unmap) else $error("unmapped access not refused");

    property p_err_hit;
        @(posedge pclk) disable iff (!presetn)
        (acc_setup && hit)
        |=> !pslverr;
    endproperty
    a_err_hit: assert property (p_err_hit) else $error("mapped access refused");

    property p_unmap_flag;
        @(posedge pclk) disable iff (!presetn)
        acc_setup
        |=> (unmap_q == !$past(hit));
    endproperty
    a_unmap_flag: assert property (p_unmap_flag) else $error("unmapped flag wrong");

    property p_rd_idle_zero;
        @(posedge pclk) disable iff (!presetn)
        !(acc_setup && !pwrite)
        |=> (prdata == '0);
    endproperty
    a_rd_idle_zero: assert property (p_rd_idle_zero) else $error("read data outside answer");

    property p_scratch_hold;
        @(posedge pclk) disable iff (!presetn)
        !wr_scratch
        |=> $stable(scratch_q);
    endproperty
    a_scratch_hold: assert property (p_scratch_hold) else $error("scratch changed without write");

    property p_scratch_wr;
        @(posedge pclk) disable iff (!presetn)
        wr_scratch
        |=> (scratch_q == $past(pwdata));
    endproperty
    a_scratch_wr: assert property (p_scratch_wr) else $error("scratch write lost");

    // ==========================================================
    // Reset checks: outputs quiet while reset is held
    property p_reset_quiet;
        @(posedge pclk)
        !presetn
        |-> (prdata == '0 && !pready && !pslverr);
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
endmodule // dapid_top

// File: dapid_dbg_model.sv
// Debugger-side APB master model for the identity block
`timescale 1ns/100ps
module dapid_dbg_model (
    // Clock
    input  wire logic        pclk,
    // APB master side
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic [11:0]      paddr,
    output logic [31:0]      pwdata,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    // Entered just after an edge; holds the request until pready is seen
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released lines flip so stale values never look valid
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule // dapid_dbg_model

// File: dapid_top_tb.sv
// Self-checking bench for the debug identity register block
`timescale 1ns/100ps
module dapid_top_tb;
    import dapid_pkg::*;
    typedef struct {logic [11:0] a; logic [31:0] m; logic [31:0] x;} dapid_row_s;
    localparam logic [19:0] ROM_BASE = 20'hA5C3E;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ok_in, e;
    logic [11:0] paddr, part;
    logic [31:0] pwdata, prdata, tid, r;
    logic [3:0]  inst, rev;
    logic [10:0] maker;
    logic [19:0] loc;
    logic [31:0] prdata_s, r_s;
    logic        pready_s, pslverr_s;
    dapid_row_s  rows [9];
    int          err_count, num_checks, cyc;
    dapid_top #(.SYS_VARIANT(1'b0), .ROM_BASE_ADDR(ROM_BASE)) uut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .target_ident_input(tid),
        .instance_ident_input(inst), .rom_maker_code_input(maker), .rom_revision_input(rev),
        .rom_part_input(part), .port_location_input(loc), .port_location_ok_input(ok_in));
    dapid_dbg_model m (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    // System-bus variant shares the request lines; its answer is caught here
    dapid_top #(.SYS_VARIANT(1'b1), .ROM_BASE_ADDR(ROM_BASE)) uut_sys (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata_s), .pready(pready_s), .pslverr(pslverr_s), .target_ident_input(tid),
        .instance_ident_input(inst), .rom_maker_code_input(maker), .rom_revision_input(rev),
        .rom_part_input(part), .port_location_input(loc), .port_location_ok_input(ok_in));
    always @(posedge pclk) begin
        if (pready_s) begin
            r_s <= prdata_s;
        end
    end
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        m.xfer(w, a, d, r, e);
    endtask
    task automatic sys_base;
        acc(1'b0, DAPID_OFS_AP_BASE, 32'h0);
        @(posedge pclk);
        check(r_s, {loc, 10'h0, 1'b1, ok_in});
    endtask
    task automatic final_report;
        $display("checks=%0d errors=%0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // Hang guard, well above the under 150 cycles needed
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            final_report();
        end
    end
    initial begin
        presetn = 1'b0;
        tid = 32'h1234_5671;
        inst = 4'h9;
        maker = 11'h4D3;
        rev = 4'hB;
        part = 12'h6E2;
        loc = 20'h3C001;
        ok_in = 1'b0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, DAPID_OFS_SCRATCH, 32'h0);
        check(r, DAPID_SCRATCH_RST);
        for (int p = 0; p < 2; p++) begin
            rows[0] = '{DAPID_OFS_PORT_ID2, 32'hFF, {24'h0, DAPID_ADDR_SPACE_SIZE_FIELD_VAL}};
            rows[1] = '{DAPID_OFS_BASE_POINTER_ZERO_REG, 32'hFFF0_0001, 32'h1};
            rows[2] = '{DAPID_OFS_TARGET_ID, 32'hFFFF_FFFE, tid};
            rows[3] = '{DAPID_OFS_LINK_ID, 32'hF000_0000, {inst, 28'h0}};
            rows[4] = '{DAPID_OFS_AP_BASE, 32'hFFFF_F001, {ROM_BASE, 12'h001}};
            rows[5] = '{DAPID_OFS_PERIPH_IDENT_REG_ZERO, 32'hFF, {24'h0, part[7:0]}};
            rows[6] = '{DAPID_OFS_PERIPH_IDENT_REG_ONE, 32'hFF, {24'h0, maker[3:0], part[11:8]}};
            rows[7] = '{DAPID_OFS_PERIPH_IDENT_REG_TWO, 32'hF7, {24'h0, rev, 1'b0, maker[6:4]}};
            rows[8] = '{DAPID_OFS_PERIPH_IDENT_REG_FOUR, 32'h0F, {28'h0, maker[10:7]}};
            foreach (rows[i]) begin
                acc(1'b1, rows[i].a, ~rows[i].x);
                check({31'h0, e}, 32'h0);
                acc(1'b0, rows[i].a, 32'h0);
                check(r & rows[i].m, rows[i].x & rows[i].m);
            end
            // Live inputs: new values must show without any capture
            tid <= ~tid;
            inst <= ~inst;
            maker <= ~maker;
            rev <= ~rev;
            part <= ~part;
            @(posedge pclk);
        end
        sys_base();
        loc <= ~loc;
        ok_in <= 1'b1;
        sys_base();
        acc(1'b1, DAPID_OFS_SCRATCH, 32'hC3A5_5A3C);
        acc(1'b1, 12'hFFC, 32'h0);
        check({31'h0, e}, 32'h1);
        acc(1'b0, DAPID_OFS_STATUS, 32'h0);
        check(r, 32'h1);
        @(posedge pclk);
        check(r_s, 32'h3);
        acc(1'b0, DAPID_OFS_SCRATCH, 32'h0);
        check(r, 32'hC3A5_5A3C);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        acc(1'b0, DAPID_OFS_SCRATCH, 32'h0);
        check(r, DAPID_SCRATCH_RST);
        final_report();
    end
endmodule // dapid_top_tb
